// ==== lph_pkg.sv ====
// Shared constants and carrier types for the LPDDR2 host-side pin driver.
// Functional notes
// - Present command/address valid around both clock edges.
// - Chip select and clock gate change per rising edge.
// - Power-saving states entered and left via clock gate.
// - Read strobe edge aligned; write strobe centred in bits.
// - Strobe n times data lines 8n to 8n+7.
// - Mask high with byte leaves stored byte unchanged.
// - Mask n governs data lines 8n to 8n+7.
// - Eight banks selected by three-bit bank address.
// - Row 14 bits; column 10 (x16) or 9 (x32).
// - Refresh bookkeeping covers 8192 refreshes per round.
// - Latencies and burst length 4, 8, 16 programmable.
// - Interface clock runs between 10 and 533 MHz.
// - Data bus bidirectional, 16 or 32 lines wide.
// - Each command occupies exactly one clock cycle.
// - Activate selects bank and row; access gives column.
package lph_pkg;

    // ------------------------------------------------------------------
    // Geometry of the command/address bus and the memory array.
    // ------------------------------------------------------------------
    localparam int CA_W = 10;
    localparam int BANK_W = 3;
    localparam int ROW_W = 14;
    localparam int COL_W = 10;
    localparam int COL_W_X32 = 9;
    localparam int LANE_W = 8;
    localparam int OPC_W = 3;
    localparam int HI_W = 4;
    localparam int CA_OPC_LSB = 0;
    localparam int CA_BANK_LSB = 3;
    localparam int CA_HI_LSB = 6;

    // Command codes carried in the low bits of the rising-edge half.
    localparam logic [2:0] OPC_ACT = 3'h1;
    localparam logic [2:0] OPC_RD = 3'h2;
    localparam logic [2:0] OPC_WR = 3'h3;
    localparam logic [2:0] OPC_PRE = 3'h4;
    localparam logic [2:0] OPC_REF = 3'h5;

    // ------------------------------------------------------------------
    // Refresh, burst and timing constants.
    // ------------------------------------------------------------------
    localparam int REFRESH_COUNT = 8192;
    localparam int REF_CNT_W = 13;
    localparam logic [12:0] REF_CNT_LAST = 13'h1fff;
    localparam logic [1:0] BL_CODE_4 = 2'h1;
    localparam logic [1:0] BL_CODE_8 = 2'h2;
    localparam logic [1:0] BL_CODE_16 = 2'h3;
    localparam logic [7:0] BL_BEATS_4 = 8'h04;
    localparam logic [7:0] BL_BEATS_8 = 8'h08;
    localparam logic [7:0] BL_BEATS_16 = 8'h10;
    localparam int T_W = 8;
    localparam int MCLK_NS = 40;
    localparam int CK_PERIOD_NS = 80;
    localparam int CK_DIV = CK_PERIOD_NS / MCLK_NS;
    localparam int RD_SLACK_NS = 320;
    localparam logic [7:0] RD_SLACK_CYC = 8'(RD_SLACK_NS / MCLK_NS);

    // ------------------------------------------------------------------
    // Carrier types.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF, OP_PD_ENTER, OP_PD_EXIT
    } lph_op_t;

    typedef struct packed {
        lph_op_t op;
        logic [2:0] bank_select;
        logic [13:0] row_addr;
        logic [9:0] column_addr;
    } lph_req_t;

    typedef struct packed {
        logic [3:0] read_latency_cycles;
        logic [3:0] write_latency_cycles;
        logic [1:0] bl_code;
    } lph_cfg_t;

endpackage

// ==== lph_host.sv ====
// Host-side driver of the LPDDR2 command, address and data pins.
module lph_host #(
    parameter int DQ_W = 32
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire lph_pkg::lph_cfg_t cfg,
    input wire logic req_valid,
    input wire lph_pkg::lph_req_t req,
    output logic req_ready,
    input wire logic [DQ_W-1:0] wr_data,
    input wire logic [DQ_W/8-1:0] wr_mask,
    output logic wr_take,
    output logic [DQ_W-1:0] rd_data,
    output logic rd_valid,
    output logic rd_timeout,
    output logic refresh_round,
    output logic ck,
    output logic ck_n,
    output logic cke,
    output logic cs_n,
    output logic [9:0] cmd_addr_bus,
    output logic [DQ_W-1:0] data_lines_o,
    output logic [DQ_W-1:0] data_lines_oe,
    input wire logic [DQ_W-1:0] data_lines_i,
    output logic [DQ_W/8-1:0] dqs_o,
    output logic [DQ_W/8-1:0] dqs_n_o,
    output logic [DQ_W/8-1:0] dqs_oe,
    input wire logic [DQ_W/8-1:0] dqs_i,
    output logic [DQ_W/8-1:0] write_byte_mask
);

    localparam int LANES = DQ_W / lph_pkg::LANE_W;

    typedef enum logic [1:0] {S_IDLE, S_CMD, S_WR, S_RD} lph_state_t;

    lph_state_t st_r, st_nxt;
    logic ph_r, ph_nxt;
    logic [7:0] t_r, t_nxt, tn, ws, we, bl, rl_end;
    logic [7:0] rd_cnt_r, rd_cnt_nxt;
    lph_pkg::lph_req_t req_r, req_nxt;
    lph_pkg::lph_cfg_t lat_r, lat_nxt;
    logic pd_r, pd_nxt, ready_r, ready_nxt, take_r, take_nxt;
    logic [12:0] ref_cnt_r, ref_cnt_nxt;
    logic ref_round_r, ref_round_nxt, rd_to_r, rd_to_nxt;
    logic cs_n_r, cs_n_nxt, cke_r, cke_nxt, dqs_lvl_r, dqs_lvl_nxt;
    logic wr_beat_r, wr_beat_nxt, oe_r, oe_nxt;
    logic [9:0] ca_r, ca_nxt;
    logic [DQ_W-1:0] dq_o_r, dq_o_nxt;
    logic [LANES-1:0] dm_r, dm_nxt;
    logic ck_r, ck_n_r;
    logic [LANES-1:0] dqs_o_r, dqs_n_o_r;
    logic [DQ_W-1:0] dq_s1_r, dq_s2_r, lane_dat_r, lane_dat_nxt, rd_data_r, rd_data_nxt;
    logic [LANES-1:0] dqs_s1_r, dqs_s2_r, dqs_s3_r, got_r, got_nxt;
    logic rd_valid_r, rd_valid_nxt;

    // ----------
    // Command/address encoding helpers.
    // ----------

    // The x32 part has one column bit fewer, so the top bit is forced low.
    function automatic logic [9:0] col_eff(input lph_pkg::lph_req_t r);
        return (DQ_W == 32) ? {1'b0, r.column_addr[8:0]} : r.column_addr;
    endfunction

    // Rising half: opcode, bank and the high address bits.
    function automatic logic [9:0] ca_rise(input lph_pkg::lph_req_t r);
        logic [9:0] ca;
        logic [9:0] c;
        ca = 10'h000;
        c = col_eff(r);
        ca[lph_pkg::CA_BANK_LSB +: lph_pkg::BANK_W] = r.bank_select;
        unique case (r.op)
            lph_pkg::OP_ACT: begin
                ca[lph_pkg::CA_OPC_LSB +: lph_pkg::OPC_W] = lph_pkg::OPC_ACT;
                ca[lph_pkg::CA_HI_LSB +: lph_pkg::HI_W] = r.row_addr[13:10];
            end
            lph_pkg::OP_READ: begin
                ca[lph_pkg::CA_OPC_LSB +: lph_pkg::OPC_W] = lph_pkg::OPC_RD;
                ca[lph_pkg::CA_HI_LSB +: lph_pkg::HI_W] = c[9:6];
            end
            lph_pkg::OP_WRITE: begin
                ca[lph_pkg::CA_OPC_LSB +: lph_pkg::OPC_W] = lph_pkg::OPC_WR;
                ca[lph_pkg::CA_HI_LSB +: lph_pkg::HI_W] = c[9:6];
            end
            lph_pkg::OP_PRE: ca[lph_pkg::CA_OPC_LSB +: lph_pkg::OPC_W] = lph_pkg::OPC_PRE;
            default: ca[lph_pkg::CA_OPC_LSB +: lph_pkg::OPC_W] = lph_pkg::OPC_REF;
        endcase
        return ca;
    endfunction

    // Falling half: low row bits for an activate, low column bits otherwise.
    function automatic logic [9:0] ca_fall(input lph_pkg::lph_req_t r);
        logic [9:0] c;
        c = col_eff(r);
        if (r.op == lph_pkg::OP_ACT) begin
            return r.row_addr[9:0];
        end
        return {4'h0, c[5:0]};
    endfunction

    function automatic logic [7:0] bl_beats(input logic [1:0] code);
        unique case (code)
            lph_pkg::BL_CODE_4: return lph_pkg::BL_BEATS_4;
            lph_pkg::BL_CODE_16: return lph_pkg::BL_BEATS_16;
            default: return lph_pkg::BL_BEATS_8;
        endcase
    endfunction

    // ----------
    // Sequencer: one interface clock is two mclk cycles, phase 0 first.
    // ----------

    // Burst window edges in mclk cycles counted from the command's first half.
    always_comb begin
        bl = bl_beats(lat_r.bl_code);
        ws = 8'(lph_pkg::CK_DIV * lat_r.write_latency_cycles);
        we = ws + bl;
        rl_end = 8'(lph_pkg::CK_DIV * lat_r.read_latency_cycles) + bl + lph_pkg::RD_SLACK_CYC;
        tn = t_r + 8'h01;
    end

    // Next state, pin values for the following cycle and bookkeeping.
    always_comb begin
        st_nxt = st_r;
        ph_nxt = ~ph_r;
        t_nxt = t_r;
        req_nxt = req_r;
        lat_nxt = lat_r;
        pd_nxt = pd_r;
        ref_cnt_nxt = ref_cnt_r;
        ref_round_nxt = 1'b0;
        rd_to_nxt = 1'b0;
        rd_cnt_nxt = rd_cnt_r;
        cs_n_nxt = cs_n_r;
        cke_nxt = cke_r;
        ca_nxt = ca_r;
        dq_o_nxt = dq_o_r;
        dm_nxt = '0;
        oe_nxt = 1'b0;
        dqs_lvl_nxt = 1'b0;
        wr_beat_nxt = 1'b0;
        take_nxt = 1'b0;
        unique case (st_r)
            S_IDLE: begin
                // Requests are taken only in phase 1 so a command starts on a rising edge.
                if (req_valid && ready_r && !(pd_r && req.op != lph_pkg::OP_PD_EXIT)) begin
                    req_nxt = req;
                    lat_nxt = cfg;
                    st_nxt = S_CMD;
                    t_nxt = 8'h00;
                    if (req.op == lph_pkg::OP_PD_ENTER) begin
                        cke_nxt = 1'b0;
                        pd_nxt = 1'b1;
                    end else if (req.op == lph_pkg::OP_PD_EXIT) begin
                        cke_nxt = 1'b1;
                        pd_nxt = 1'b0;
                    end else begin
                        cs_n_nxt = 1'b0;
                        ca_nxt = ca_rise(req);
                    end
                end
            end
            S_CMD: begin
                t_nxt = tn;
                if (t_r == 8'h00) begin
                    ca_nxt = ca_fall(req_r);
                end else begin
                    // Chip select returns high after exactly one interface clock.
                    cs_n_nxt = 1'b1;
                    ca_nxt = 10'h000;
                    st_nxt = S_IDLE;
                    if (req_r.op == lph_pkg::OP_WRITE) begin
                        st_nxt = S_WR;
                        oe_nxt = (tn >= ws - 8'h02);
                    end else if (req_r.op == lph_pkg::OP_READ) begin
                        st_nxt = S_RD;
                        rd_cnt_nxt = 8'h00;
                    end else if (req_r.op == lph_pkg::OP_REF) begin
                        ref_cnt_nxt = ref_cnt_r + 13'h0001;
                        ref_round_nxt = (ref_cnt_r == lph_pkg::REF_CNT_LAST);
                    end
                end
            end
            S_WR: begin
                t_nxt = tn;
                // One interface clock of preamble with the strobe held low.
                oe_nxt = (tn >= ws - 8'h02) && (tn < we);
                if (tn >= ws && tn < we) begin
                    dq_o_nxt = wr_data;
                    dm_nxt = wr_mask;
                    wr_beat_nxt = 1'b1;
                    dqs_lvl_nxt = ~ph_nxt;
                end
                take_nxt = (t_r + 8'h02 >= ws) && (t_r + 8'h02 < we);
                if (tn == we) begin
                    st_nxt = S_IDLE;
                end
            end
            S_RD: begin
                t_nxt = tn;
                // A lost strobe must not hang the sequencer, hence the timeout.
                if (rd_valid_nxt) begin
                    rd_cnt_nxt = rd_cnt_r + 8'h01;
                    if (rd_cnt_r + 8'h01 == bl) begin
                        st_nxt = S_IDLE;
                    end
                end else if (t_r >= rl_end) begin
                    st_nxt = S_IDLE;
                    rd_to_nxt = 1'b1;
                end
            end
        endcase
        ready_nxt = (st_nxt == S_IDLE) && ph_nxt;
    end

    // Register the sequencer state and all command-side pins.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= S_IDLE;
            ph_r <= 1'b1;
            t_r <= 8'h00;
            req_r <= '0;
            lat_r <= '0;
            pd_r <= 1'b1;
            ref_cnt_r <= 13'h0000;
            ref_round_r <= 1'b0;
            rd_to_r <= 1'b0;
            rd_cnt_r <= 8'h00;
            ready_r <= 1'b0;
            take_r <= 1'b0;
            cs_n_r <= 1'b1;
            cke_r <= 1'b0;
            ca_r <= 10'h000;
            dq_o_r <= '0;
            dm_r <= '0;
            oe_r <= 1'b0;
            dqs_lvl_r <= 1'b0;
            wr_beat_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            t_r <= t_nxt;
            req_r <= req_nxt;
            lat_r <= lat_nxt;
            pd_r <= pd_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            ref_round_r <= ref_round_nxt;
            rd_to_r <= rd_to_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            ready_r <= ready_nxt;
            take_r <= take_nxt;
            cs_n_r <= cs_n_nxt;
            cke_r <= cke_nxt;
            ca_r <= ca_nxt;
            dq_o_r <= dq_o_nxt;
            dm_r <= dm_nxt;
            oe_r <= oe_nxt;
            dqs_lvl_r <= dqs_lvl_nxt;
            wr_beat_r <= wr_beat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Clock and write strobe move on the falling mclk edge, so their edges
    // land half an mclk into each command or data half and stay centred.
    // ------------------------------------------------------------------
    always_ff @(negedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ck_r <= 1'b0;
            ck_n_r <= 1'b1;
            dqs_o_r <= '0;
            dqs_n_o_r <= '1;
        end else begin
            ck_r <= ~ph_r;
            ck_n_r <= ph_r;
            dqs_o_r <= {LANES{dqs_lvl_r}};
            dqs_n_o_r <= {LANES{~dqs_lvl_r}};
        end
    end

    // ------------------------------------------------------------------
    // Read capture: pins pass two flip-flops, then each lane takes its byte
    // on every change of its own strobe during a read. Data and strobe share the same
    // synchroniser delay, which trades capture margin for simplicity.
    // ------------------------------------------------------------------
    always_comb begin
        lane_dat_nxt = lane_dat_r;
        got_nxt = got_r;
        rd_valid_nxt = 1'b0;
        rd_data_nxt = rd_data_r;
        for (int n = 0; n < LANES; n++) begin
            if (st_r == S_RD && dqs_s2_r[n] != dqs_s3_r[n]) begin
                lane_dat_nxt[n*lph_pkg::LANE_W +: lph_pkg::LANE_W] =
                    dq_s2_r[n*lph_pkg::LANE_W +: lph_pkg::LANE_W];
                got_nxt[n] = 1'b1;
            end
        end
        if (&got_nxt) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = lane_dat_nxt;
            got_nxt = '0;
        end
        if (st_r != S_RD) begin
            got_nxt = '0;
        end
    end

    // Register synchronisers and the capture state.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            dqs_s1_r <= '0;
            dqs_s2_r <= '0;
            dqs_s3_r <= '0;
            lane_dat_r <= '0;
            got_r <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            dq_s1_r <= data_lines_i;
            dq_s2_r <= dq_s1_r;
            dqs_s1_r <= dqs_i;
            dqs_s2_r <= dqs_s1_r;
            dqs_s3_r <= dqs_s2_r;
            lane_dat_r <= lane_dat_nxt;
            got_r <= got_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign req_ready = ready_r;
    assign wr_take = take_r;
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign rd_timeout = rd_to_r;
    assign refresh_round = ref_round_r;
    assign ck = ck_r;
    assign ck_n = ck_n_r;
    assign cke = cke_r;
    assign cs_n = cs_n_r;
    assign cmd_addr_bus = ca_r;
    assign data_lines_o = dq_o_r;
    assign data_lines_oe = {DQ_W{oe_r}};
    assign dqs_o = dqs_o_r;
    assign dqs_n_o = dqs_n_o_r;
    assign dqs_oe = {LANES{oe_r}};
    assign write_byte_mask = dm_r;

    // ----------
    // Checks.
    // ----------
    default clocking chk_cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence cmd_slot_s;
        !cs_n_r ##1 cs_n_r;
    endsequence
    sequence burst4_s;
        wr_beat_r [*4] ##1 !wr_beat_r;
    endsequence
    sequence burst8_s;
        wr_beat_r [*8] ##1 !wr_beat_r;
    endsequence

    chk_cmd_one_clock: assert property ($fell(cs_n_r) |-> ##1 cmd_slot_s)
        else $error("command select not held for one interface clock");
    chk_sdr_rise_align: assert property (($changed(cs_n_r) || $changed(cke_r)) |-> !ph_r)
        else $error("select or clock gate changed off the rising half");
    chk_clock_pair: assert property (ck_r == !ph_r && ck_n_r == ph_r)
        else $error("interface clock pair out of phase");
    chk_wr_preamble: assert property ($rose(oe_r) |-> st_r == S_WR && t_r == ws - 8'h02)
        else $error("write drive began at the wrong latency");
    chk_strobe_centre: assert property (wr_beat_r |-> dqs_o_r[0] == !ph_r && oe_r)
        else $error("write strobe not centred in beat");
    chk_mask_data: assert property (take_r |=> dm_r == $past(wr_mask) && dq_o_r == $past(wr_data))
        else $error("write beat or mask not presented");
    chk_bus_turn: assert property (oe_r |-> st_r == S_WR)
        else $error("data bus driven outside a write");
    chk_burst_four: assert property (($rose(wr_beat_r) && bl == 8'h04) |-> burst4_s)
        else $error("burst of four has wrong length");
    chk_burst_eight: assert property (($rose(wr_beat_r) && bl == 8'h08) |-> burst8_s)
        else $error("burst of eight has wrong length");
    chk_refresh_wrap: assert property (ref_round_r |-> ref_cnt_r == 13'h0000)
        else $error("refresh round flagged off the wrap");
    chk_pd_gate: assert property ($changed(cke_r) |-> cs_n_r && (st_r == S_CMD))
        else $error("clock gate moved during a selected command");
    chk_act_row: assert property (($fell(cs_n_r) && req_r.op == lph_pkg::OP_ACT)
        |-> ca_r[2:0] == lph_pkg::OPC_ACT ##1 ca_r == req_r.row_addr[9:0])
        else $error("activate did not carry its row");

endmodule

// ==== lph_dev.sv ====
// Behavioural memory device that answers the host pin driver.
module lph_dev (
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [9:0] cmd_addr_bus,
    input wire logic [31:0] dq,
    input wire logic [3:0] dqs,
    input wire logic [3:0] write_byte_mask,
    input wire logic [3:0] rl,
    input wire logic [7:0] bl,
    input wire logic short_rd,
    output logic [31:0] dq_d,
    output logic [3:0] dqs_d,
    output int cmd_cnt,
    output int ref_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] half0;
    logic sel = 1'b0;
    logic wr_on = 1'b0;
    logic [2:0] wbank;
    logic [13:0] open_row [8];
    logic [7:0] mem [int];
    int wbeat;
    int wcol;
    int wbl;

    initial begin
        dq_d = '0;
        dqs_d = '0;
        cmd_cnt = 0;
        ref_cnt = 0;
    end

    // Array key: the open row of the bank is part of every location.
    function automatic int key(input logic [2:0] b, input int c, input int l);
        return int'({b, open_row[b], c[9:0], l[1:0]});
    endfunction

    // ----------
    // Command decode
    // ----------
    // The first half is taken at the rising crossing, and only while the gate is high.
    always @(posedge ck) begin
        sel <= cke && !cs_n;
        half0 <= cmd_addr_bus;
    end

    // The second half completes the command at the falling crossing.
    always @(negedge ck) if (sel) begin
        cmd_cnt <= cmd_cnt + 1;
        case (half0[2:0])
            lph_pkg::OPC_ACT: open_row[half0[5:3]] <= {half0[9:6], cmd_addr_bus};
            lph_pkg::OPC_WR: begin
                wbank = half0[5:3];
                wcol = int'({half0[9:6], cmd_addr_bus[5:0]});
                wbeat = 0;
                wbl = int'(bl);
                wr_on = 1'b1;
            end
            lph_pkg::OPC_RD: fork
                do_read(half0[5:3], int'({half0[9:6], cmd_addr_bus[5:0]}));
            join_none
            lph_pkg::OPC_REF: ref_cnt <= ref_cnt + 1;
            default: ;
        endcase
    end

    // ----------
    // Data path
    // ----------
    // Every strobe crossing of a write burst is one beat; masked lanes keep their byte.
    always @(dqs[0]) if (wr_on) begin
        for (int l = 0; l < 4; l++) if (!write_byte_mask[l])
            mem[key(wbank, wcol + wbeat, l)] = dq[8*l +: 8];
        wbeat++;
        if (wbeat == wbl) wr_on = 1'b0;
    end

    // Beats last 80 ns so the host synchroniser sees each one; short bursts are on demand.
    task automatic do_read(input logic [2:0] b, input int c);
        int n;
        n = short_rd ? int'(bl) - 2 : int'(bl);
        repeat (rl) @(posedge ck);
        for (int k = 0; k < n; k++) begin
            for (int l = 0; l < 4; l++)
                dq_d[8*l +: 8] = mem.exists(key(b, c + k, l)) ? mem[key(b, c + k, l)] : 8'hee;
            dqs_d = ~dqs_d;
            #80;
        end
        dqs_d = '0;
        dq_d = ~dq_d;
    endtask
endmodule

// ==== lph_host_tb.sv ====
// Self-checking bench for the host pin driver against the behavioural device.
module lph_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] blc;
        logic [3:0] wl;
        logic [3:0] rl;
        logic [2:0] bank;
        logic [13:0] row;
        logic [9:0] col;
        logic [3:0] mask;
        logic [7:0] base;
    } lph_row_t;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    lph_pkg::lph_cfg_t cfg = '0;
    logic req_valid = 1'b0;
    lph_pkg::lph_req_t req = '0;
    logic [7:0] wr_base = 8'h00;
    logic [7:0] wr_idx = 8'h00;
    logic [3:0] wr_mv = 4'h0;
    logic short_rd = 1'b0;
    logic [31:0] wr_data, rd_data, dq_o, dq_oe, dq_w, dq_d;
    logic [3:0] wr_mask, dqs_o, dqs_n_o, dqs_oe, dqs_w, dqs_d, wbm;
    logic wr_take, rd_valid, rd_timeout, refresh_round, req_ready, ck, ck_n, cke, cs_n;
    logic [9:0] ca;
    int failures = 0;
    int comparisons = 0;
    int rr_cnt = 0;
    int to_cnt = 0;
    int cmd_cnt, ref_cnt;
    logic [31:0] rdq [$];
    lph_row_t rows [4] = '{
        '{2'h1, 4'h2, 4'h3, 3'h0, 14'h0005, 10'h010, 4'h5, 8'h10},
        '{2'h2, 4'h3, 4'h4, 3'h7, 14'h3fff, 10'h03f, 4'ha, 8'h20},
        '{2'h3, 4'h4, 4'h8, 3'h3, 14'h2000, 10'h1c0, 4'hf, 8'h30},
        '{2'h1, 4'h2, 4'h2, 3'h5, 14'h0123, 10'h000, 4'h0, 8'h40}};

    // ----------
    // Clock, wires and instances
    // ----------
    always #20 mclk = ~mclk;
    // Whoever enables a line owns it; otherwise the device side shows through.
    assign dq_w = (dq_oe & dq_o) | (~dq_oe & dq_d);
    assign dqs_w = (dqs_oe & dqs_o) | (~dqs_oe & dqs_d);
    assign wr_data = {4{wr_base + wr_idx}};
    assign wr_mask = wr_idx[0] ? wr_mv : 4'h0;

    lph_host #(.DQ_W(32)) lph_host_inst (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .wr_data(wr_data),
        .wr_mask(wr_mask), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_timeout(rd_timeout), .refresh_round(refresh_round), .ck(ck), .ck_n(ck_n),
        .cke(cke), .cs_n(cs_n), .cmd_addr_bus(ca), .data_lines_o(dq_o),
        .data_lines_oe(dq_oe), .data_lines_i(dq_w), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o),
        .dqs_oe(dqs_oe), .dqs_i(dqs_w), .write_byte_mask(wbm));
    lph_dev lph_dev_inst (.ck(ck), .cke(cke), .cs_n(cs_n), .cmd_addr_bus(ca), .dq(dq_w),
        .dqs(dqs_w), .write_byte_mask(wbm), .rl(cfg.read_latency_cycles),
        .bl(blb(cfg.bl_code)), .short_rd(short_rd), .dq_d(dq_d), .dqs_d(dqs_d),
        .cmd_cnt(cmd_cnt), .ref_cnt(ref_cnt));

    // Collect read beats and pulses; the write beat index follows each take.
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) rdq.push_back(rd_data);
        if (wr_take === 1'b1) wr_idx <= wr_idx + 8'h01;
        rr_cnt += int'(refresh_round === 1'b1);
        to_cnt += int'(rd_timeout === 1'b1);
    end

    // ----------
    // Tasks
    // ----------
    function automatic logic [7:0] blb(input logic [1:0] c);
        return c == lph_pkg::BL_CODE_4 ? lph_pkg::BL_BEATS_4 :
            c == lph_pkg::BL_CODE_16 ? lph_pkg::BL_BEATS_16 : lph_pkg::BL_BEATS_8;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A wait that ran out is a failure and ends the run at once.
    task automatic bounded(input int i, input int lim);
        if (i >= lim) begin
            failures++;
            conclude();
        end
    endtask

    // Hold the request until the edge that finds the host ready.
    task automatic send(input lph_pkg::lph_op_t op, input logic [2:0] b = 3'h0,
                        input logic [13:0] rw = 14'h0, input logic [9:0] c = 10'h0);
        int i;
        i = 0;
        @(posedge mclk);
        req <= '{op, b, rw, c};
        req_valid <= 1'b1;
        do begin
            @(negedge mclk);
            i++;
        end while (req_ready !== 1'b1 && i < 60);
        bounded(i, 60);
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask

    // Read four beats back; odd beats carry the mask of the row.
    task automatic rd_burst(input lph_row_t r);
        int i;
        logic [31:0] e;
        i = 0;
        rdq.delete();
        send(lph_pkg::OP_READ, r.bank, 14'h0, r.col);
        while (rdq.size() < 4 && i < 80) begin
            @(posedge mclk);
            i++;
        end
        bounded(i, 80);
        for (int k = 0; k < 4; k++) begin
            for (int l = 0; l < 4; l++)
                e[8*l +: 8] = (k % 2 == 1 && r.mask[l]) ? 8'hee : r.base + 8'(k);
            chk(rdq[k], e);
        end
    endtask

    // ----------
    // Main sequence
    // ----------
    initial begin
        int i;
        int c0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chk(32'({cke, cs_n, ck, ck_n, req_ready}), 32'h0a);
        send(lph_pkg::OP_WRITE);
        chk(cmd_cnt, 32'h0);
        send(lph_pkg::OP_PD_EXIT);
        @(negedge mclk);
        chk(32'(cke), 32'h1);
        // Each row writes a burst of its own length, then reads four beats back.
        foreach (rows[n]) begin
            cfg <= '{rows[n].rl, rows[n].wl, rows[n].blc};
            wr_base <= rows[n].base;
            wr_mv <= rows[n].mask;
            wr_idx <= 8'h00;
            send(lph_pkg::OP_ACT, rows[n].bank, rows[n].row, 10'h0);
            send(lph_pkg::OP_WRITE, rows[n].bank, 14'h0, rows[n].col);
            i = 0;
            while (wr_idx != blb(rows[n].blc) && i < 100) begin
                @(posedge mclk);
                i++;
            end
            bounded(i, 100);
            cfg.bl_code <= lph_pkg::BL_CODE_4;
            rd_burst(rows[n]);
        end
        // A read that stops two beats short must end in the timeout pulse.
        short_rd <= 1'b1;
        rdq.delete();
        c0 = to_cnt;
        send(lph_pkg::OP_READ, rows[3].bank, 14'h0, 10'h0);
        i = 0;
        while (to_cnt == c0 && i < 80) begin
            @(posedge mclk);
            i++;
        end
        chk(32'(to_cnt - c0), 32'h1);
        chk(32'(rdq.size()), 32'h2);
        short_rd <= 1'b0;
        // A full refresh round gives exactly one wrap pulse.
        for (int r = 0; r < lph_pkg::REFRESH_COUNT; r++) send(lph_pkg::OP_REF);
        repeat (4) @(posedge mclk);
        chk(32'(rr_cnt), 32'h1);
        chk(ref_cnt, 32'(lph_pkg::REFRESH_COUNT));
        // Power-down drops a read and keeps the gate low.
        send(lph_pkg::OP_PD_ENTER);
        @(negedge mclk);
        chk(32'(cke), 32'h0);
        c0 = cmd_cnt;
        send(lph_pkg::OP_READ);
        repeat (4) @(posedge mclk);
        chk(cmd_cnt, c0);
        // A second reset in mid-run returns the pins to rest.
        rst_b <= 1'b0;
        repeat (2) @(negedge mclk);
        chk(32'({cke, cs_n, ck, ck_n, req_ready}), 32'h0a);
        @(posedge mclk);
        rst_b <= 1'b1;
        send(lph_pkg::OP_PD_EXIT);
        @(negedge mclk);
        chk(32'(cke), 32'h1);
        conclude();
    end
endmodule
